// ### design/msml_pkg.sv
// Purpose: constants and types shared by the motor start and memory lockout logic
// Assumes: 100 MHz pclk; the internal time base ticks once a millisecond
// Notes:   current levels are in the same units as the maximum-load setting
package msml_pkg;
	localparam int CLK_NS        = 10;
	localparam int TICK_NS       = 1000000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_NS;
	localparam int TICKS_PER_S   = 1000;
	localparam int COOL_MIN      = 30;
	localparam int COOL_TICKS    = COOL_MIN * 60 * TICKS_PER_S;
	localparam int START_MIN_S   = 4;
	localparam int START_MAX_S   = 60;
	localparam int START_PCT     = 15;
	localparam int PCT_FULL      = 100;
	localparam int EMERG_S       = 3;

	// register byte offsets
	localparam logic [11:0] SET_OFF  = 12'h000;
	localparam logic [11:0] OPT_OFF  = 12'h004;
	localparam logic [11:0] STAT_OFF = 12'h008;
	localparam logic [11:0] MEM_OFF  = 12'h00c;

	// field positions
	localparam int SET_MAX_LSB   = 0;
	localparam int SET_UC_LSB    = 12;
	localparam int SET_START_LSB = 19;
	localparam int STAT_LIT_LSB  = 8;

	// values after reset: max load 100, undercurrent 50 %, start time 20 s
	localparam logic [31:0] SET_RST = 32'h00a32064;
	localparam logic [31:0] OPT_RST = 32'h00000000;

	typedef struct packed {
		logic [5:0]  start_s;
		logic [6:0]  uc_pct;
		logic [11:0] max_load;
	} msml_set_type;

	typedef struct packed {
		logic uc_disable;
		logic aux_uc;
		logic emerg_en;
		logic memory_defeat_switch;
		logic start_defeat;
	} msml_opt_type;

	typedef struct packed {
		logic trip;
		logic start;
		logic overload;
		logic undercurrent;
		logic lockout;
	} msml_light_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_RUN,
		ST_TRIP,
		ST_LOCK,
		ST_OFF
	} msml_state_type;
endpackage

// ### design/msml_top.sv
// Purpose: start timer, undercurrent, thermal memory and lockout of a motor relay
// Assumes: all inputs synchronous to pclk; apb access phase completes without wait states
// Notes:   other trips arrive on trip_other and never lock out
`timescale 1ns/1ps

module msml_top #(
	parameter int TICK_CYCLES = msml_pkg::TICK_CYCLES,
	parameter int TICKS_PER_S = msml_pkg::TICKS_PER_S,
	parameter int COOL_TICKS  = msml_pkg::COOL_TICKS
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	input  wire logic [11:0]        motor_current,
	input  wire logic               power_good,
	input  wire logic               reset_button,
	input  wire logic               emerg_contact,
	input  wire logic               trip_other,
	output msml_pkg::msml_light_type lights,
	output logic                    aux_relay
);
	localparam int EMERG_TICKS = msml_pkg::EMERG_S * TICKS_PER_S;

	msml_pkg::msml_set_type   set;
	msml_pkg::msml_opt_type   opt;
	msml_pkg::msml_state_type state;
	logic [31:0]              tick_cnt;
	logic                     tick;
	logic [31:0]              start_cnt;
	logic [31:0]              lock_cnt;
	logic [31:0]              mem;
	logic [31:0]              mem_sum;
	logic [31:0]              emerg_cnt;
	logic                     emerg_done;
	logic [18:0]              start_prod;
	logic [18:0]              uc_prod;
	logic [11:0]              start_thr;
	logic [11:0]              uc_thr;
	logic [5:0]               start_s;
	logic [31:0]              start_lim;
	logic                     over;
	logic                     overheat;
	logic                     do_lock;
	logic                     apb_acc;
	logic [31:0]              next_rd;
	logic                     next_err;

	assign start_prod = set.max_load * 7'(msml_pkg::START_PCT);
	assign uc_prod    = set.max_load * set.uc_pct;
	assign start_thr  = 12'(start_prod / 19'(msml_pkg::PCT_FULL));
	assign uc_thr     = 12'(uc_prod / 19'(msml_pkg::PCT_FULL));
	// clamp the start-time setting to its legal span
	assign start_s    = (set.start_s < 6'(msml_pkg::START_MIN_S)) ? 6'(msml_pkg::START_MIN_S) :
		(set.start_s > 6'(msml_pkg::START_MAX_S)) ? 6'(msml_pkg::START_MAX_S) : set.start_s;
	assign start_lim  = 32'(start_s) * 32'(TICKS_PER_S);
	assign over       = motor_current > set.max_load;
	assign overheat   = mem >= 32'(COOL_TICKS);
	assign mem_sum    = mem + 32'(motor_current);
	// defeat switch keeps any trip resettable
	assign do_lock    = !opt.memory_defeat_switch;

	// single time base for every timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt <= 32'h0;
			tick     <= 1'b0;
		end
		else if (tick_cnt == 32'(TICK_CYCLES - 1))
		begin
			tick_cnt <= 32'h0;
			tick     <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + 32'h1;
			tick     <= 1'b0;
		end
	end

	// main state and indicators, evaluated once a tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state  <= msml_pkg::ST_IDLE;
			lights <= '0;
		end
		else if (tick)
		begin
			unique case (state)
				msml_pkg::ST_OFF:
				begin
					// relock when power returns inside the cooling time
					if (power_good && lock_cnt != 32'h0 && do_lock)
					begin
						state <= msml_pkg::ST_LOCK;
						// no cause shown after a power-up relock
						lights <= '{trip: 1'b1, lockout: 1'b1, default: 1'b0};
					end
					else if (power_good)
						state <= msml_pkg::ST_IDLE;
				end
				msml_pkg::ST_TRIP:
				begin
					if (!power_good)
					begin
						state  <= msml_pkg::ST_OFF;
						lights <= '0;
					end
					else if (reset_button)
					begin
						state  <= msml_pkg::ST_IDLE;
						lights <= '0;
					end
				end
				msml_pkg::ST_LOCK:
				begin
					if (!power_good)
					begin
						state  <= msml_pkg::ST_OFF;
						lights <= '0;
					end
					// reset only works once cooled or discharged
					else if (lock_cnt == 32'h0 || emerg_done)
					begin
						state         <= msml_pkg::ST_TRIP;
						lights.lockout <= 1'b0;
					end
				end
				default:
				begin
					lights.overload     <= over;
					lights.undercurrent <= !opt.uc_disable && motor_current < uc_thr;
					lights.start        <= state == msml_pkg::ST_START;
					if (!power_good)
					begin
						state  <= msml_pkg::ST_OFF;
						lights <= '0;
					end
					else if (trip_other)
					begin
						state       <= msml_pkg::ST_TRIP;
						lights.trip <= 1'b1;
					end
					// inrush above 15 % of max load starts the timer
					// defeat goes straight to the run curve
					else if (state == msml_pkg::ST_IDLE && motor_current > start_thr)
						state <= opt.start_defeat ? msml_pkg::ST_RUN : msml_pkg::ST_START;
					// still at or above max load at the end of start time
					else if (state == msml_pkg::ST_START && start_cnt >= start_lim && !(
						motor_current < set.max_load))
					begin
						state          <= do_lock ? msml_pkg::ST_LOCK : msml_pkg::ST_TRIP;
						lights.trip    <= 1'b1;
						lights.start   <= 1'b1;
						lights.overload <= 1'b1;
						lights.lockout <= do_lock;
					end
					// drop below max load ends start mode
					else if (state == msml_pkg::ST_START && motor_current < set.max_load)
						state <= msml_pkg::ST_RUN;
					// run-mode overloads trip when the memory is full
					else if (state == msml_pkg::ST_RUN && over && overheat)
					begin
						state          <= do_lock ? msml_pkg::ST_LOCK : msml_pkg::ST_TRIP;
						lights.trip    <= 1'b1;
						lights.lockout <= do_lock;
					end
					else if (motor_current == 12'h0)
						state <= msml_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// start timer counts ticks spent in start mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			start_cnt <= 32'h0;
		else if (state != msml_pkg::ST_START)
			start_cnt <= 32'h0;
		else if (tick)
			start_cnt <= start_cnt + 32'h1;
	end

	// thirty-minute cooling time after an overheating trip
	// keeps counting with control power lost
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lock_cnt <= 32'h0;
		else if (emerg_done)
			lock_cnt <= 32'h0;
		// a power loss while running must not arm a relock at power return
		else if (tick && state != msml_pkg::ST_LOCK && state != msml_pkg::ST_OFF)
			lock_cnt <= (state == msml_pkg::ST_RUN || state == msml_pkg::ST_START) &&
				do_lock && power_good ? 32'(COOL_TICKS) : 32'h0;
		else if (tick && lock_cnt != 32'h0)
			lock_cnt <= lock_cnt - 32'h1;
	end

	// heat integrates current while above max load or starting
	// one unit per tick drains a full memory within thirty minutes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mem <= 32'h0;
		else if (emerg_done)
			mem <= 32'h0;
		else if (tick && power_good && (over || state == msml_pkg::ST_START))
			// saturate on the sum so a full memory never outlasts the cooling time
			mem <= (mem_sum >= 32'(COOL_TICKS)) ? 32'(COOL_TICKS) : mem_sum;
		else if (tick && mem != 32'h0)
			mem <= mem - 32'h1;
	end

	// contact must be held for several seconds
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			emerg_cnt  <= 32'h0;
			emerg_done <= 1'b0;
		end
		else if (!emerg_contact || !opt.emerg_en)
		begin
			emerg_cnt  <= 32'h0;
			emerg_done <= 1'b0;
		end
		else if (tick && emerg_cnt < 32'(EMERG_TICKS))
		begin
			emerg_cnt  <= emerg_cnt + 32'h1;
			emerg_done <= emerg_cnt == 32'(EMERG_TICKS - 1);
		end
		else
			emerg_done <= 1'b0;
	end

	// released as soon as current recovers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			aux_relay <= 1'b0;
		else if (tick)
			aux_relay <= power_good && opt.aux_uc && !opt.uc_disable && motor_current < uc_thr;
	end

	// apb slave: answer registered at setup, so the access phase never waits
	assign apb_acc = psel && penable && pready;

	always_comb
	begin
		next_rd  = 32'h0;
		next_err = 1'b0;
		unique case (paddr)
			msml_pkg::SET_OFF:  next_rd = 32'(set);
			msml_pkg::OPT_OFF:  next_rd = 32'(opt);
			msml_pkg::STAT_OFF: next_rd = 32'(state) | (32'(lights) << msml_pkg::STAT_LIT_LSB);
			msml_pkg::MEM_OFF:  next_rd = mem;
			default:            next_err = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? next_rd : 32'h0;
			pslverr <= psel && !penable && next_err;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			set <= msml_pkg::msml_set_type'(msml_pkg::SET_RST[24:0]);
			opt <= msml_pkg::msml_opt_type'(msml_pkg::OPT_RST[4:0]);
		end
		else if (apb_acc && pwrite && paddr == msml_pkg::SET_OFF)
			set <= msml_pkg::msml_set_type'(pwdata[24:0]);
		else if (apb_acc && pwrite && paddr == msml_pkg::OPT_OFF)
			opt <= msml_pkg::msml_opt_type'(pwdata[4:0]);
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_start_entry: assert property (tick && power_good && state == msml_pkg::ST_IDLE && !trip_other
		&& motor_current > start_thr && !opt.start_defeat |=> state == msml_pkg::ST_START)
		else $error("start mode not entered");
	chk_start_exit: assert property (tick && power_good && state == msml_pkg::ST_START && !trip_other
		&& start_cnt < start_lim && motor_current < set.max_load |=> state == msml_pkg::ST_RUN)
		else $error("start mode not left");
	chk_start_expire: assert property (tick && power_good && state == msml_pkg::ST_START && !trip_other
		&& start_cnt >= start_lim && motor_current >= set.max_load
		|=> lights.trip && lights.start && lights.overload)
		else $error("start timeout without trip");
	chk_defeat_skip: assert property ($rose(state == msml_pkg::ST_START) |-> $past(!opt.start_defeat))
		else $error("start mode while defeated");
	chk_uc_aux: assert property (tick && power_good && opt.aux_uc && !opt.uc_disable
		&& motor_current < uc_thr |=> aux_relay)
		else $error("aux not energised");
	chk_uc_release: assert property (tick && motor_current >= uc_thr |=> !aux_relay ##1 !aux_relay[*1])
		else $error("aux not released");
	chk_lock_reset: assert property (state == msml_pkg::ST_LOCK && lock_cnt > 32'h1 && !emerg_done
		&& power_good |=> state == msml_pkg::ST_LOCK)
		else $error("lockout left early");
	chk_no_lock: assert property ($rose(state == msml_pkg::ST_LOCK) |-> $past(!opt.memory_defeat_switch))
		else $error("lockout while defeated");
	chk_emerg_clear: assert property (emerg_done |=> mem == 32'h0 && lock_cnt == 32'h0)
		else $error("emergency discharge failed");
	chk_power_relock: assert property (tick && state == msml_pkg::ST_OFF && power_good
		&& lock_cnt != 32'h0 && do_lock |=> state == msml_pkg::ST_LOCK && !lights.start
		&& !lights.overload)
		else $error("no relock at power up");
endmodule // msml_top

// ### tb/msml_field_model.sv
// Purpose: motor current, panel and contact side of the lockout block
// Assumes: levels change by non-blocking assignment after a rising edge
// Notes:   steered by the bench through its tasks
`timescale 1ns/1ps
module msml_field_model (
	input  wire logic   pclk,
	output logic [11:0] motor_current,
	output logic        power_good,
	output logic        reset_button,
	output logic        emerg_contact,
	output logic        trip_other
);
	initial
	begin
		motor_current = 12'h000;
		power_good = 1'b1;
		reset_button = 1'b0;
		emerg_contact = 1'b0;
		trip_other = 1'b0;
	end

	task automatic drive(input logic [11:0] cur, input logic pg, input logic tr);
		@(posedge pclk);
		motor_current <= cur;
		power_good <= pg;
		trip_other <= tr;
	endtask

	// contact held for seconds
	// buttons are held over several ticks, a short press could miss a tick
	task automatic hold(input logic rb, input logic ec, input int n);
		@(posedge pclk);
		reset_button <= rb;
		emerg_contact <= ec;
		repeat (n) @(posedge pclk);
		reset_button <= 1'b0;
		emerg_contact <= 1'b0;
	endtask
endmodule // msml_field_model

// ### tb/msml_top_tb_top.sv
// Purpose: self-checking bench for the motor start and memory lockout block
// Assumes: short tick, second and cooling counts keep the run brief
// Notes:   state is followed through the status register
`timescale 1ns/1ps
module msml_top_tb_top;
	localparam int TCY = 4;
	localparam int TPS = 4;
	logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]              paddr, motor_current;
	logic [31:0]              pwdata, prdata, rd;
	logic                     power_good, reset_button, emerg_contact, trip_other, aux_relay;
	msml_pkg::msml_light_type lights;
	msml_pkg::msml_set_type   set_v;
	int                       bad_count = 0;
	int                       checks = 0;
	int                       cyc = 0;
	int                       t0;

	msml_top #(.TICK_CYCLES(TCY), .TICKS_PER_S(TPS), .COOL_TICKS(50)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .motor_current(motor_current),
		.power_good(power_good), .reset_button(reset_button),
		.emerg_contact(emerg_contact), .trip_other(trip_other),
		.lights(lights), .aux_relay(aux_relay));

	msml_field_model pm_u (.pclk(pclk), .motor_current(motor_current),
		.power_good(power_good), .reset_button(reset_button),
		.emerg_contact(emerg_contact), .trip_other(trip_other));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) cyc <= cyc + 1;

	task automatic test_done();
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_lights(input logic [4:0] exp);
		checks++;
		if (lights !== exp)
		begin
			bad_count++;
			$display("ERROR %0t lights %b expected %b", $time, lights, exp);
		end
	endtask

	// holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp_word(rd, exp);
	endtask

	task automatic wait_state(input logic [2:0] s, input int polls);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, msml_pkg::STAT_OFF, 32'h0);
			n++;
		end
		while (rd[2:0] !== s && n < polls);
		cmp_word({29'h0, rd[2:0]}, {29'h0, s});
	endtask

	task automatic ticks(input int n);
		repeat (n * TCY) @(posedge pclk);
	endtask

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(msml_pkg::STAT_OFF, 32'h0);
		rd_chk(msml_pkg::SET_OFF, msml_pkg::SET_RST);
		rd_chk(msml_pkg::OPT_OFF, msml_pkg::OPT_RST);
		apb(1'b0, 12'h010, 32'h0);
		cmp_word({31'h0, err}, 32'h1);
		set_v = '{start_s: 6'd4, uc_pct: 7'd50, max_load: 12'd100};
		apb(1'b1, msml_pkg::SET_OFF, 32'(set_v));
		rd_chk(msml_pkg::SET_OFF, 32'(set_v));
		// start timeout, lockout, emergency restart
		apb(1'b1, msml_pkg::OPT_OFF, 32'h14);
		pm_u.drive(12'd200, 1'b1, 1'b0);
		wait_state(3'd1, 5);
		ticks(12);
		wait_state(3'd1, 1);
		wait_state(3'd4, 12);
		cmp_lights(5'b11101);
		pm_u.drive(12'd0, 1'b1, 1'b0);
		pm_u.hold(1'b1, 1'b0, 3 * TCY);
		wait_state(3'd4, 1);
		pm_u.hold(1'b0, 1'b1, 4 * TPS * TCY);
		wait_state(3'd3, 10);
		cmp_lights(5'b11100);
		rd_chk(msml_pkg::MEM_OFF, 32'h0);
		pm_u.hold(1'b1, 1'b0, 3 * TCY);
		wait_state(3'd0, 5);
		cmp_lights(5'b00000);
		// undercurrent edge at exactly half of max load, aux off and on
		for (int a = 0; a < 2; a++)
		begin
			apb(1'b1, msml_pkg::OPT_OFF, a ? 32'h08 : 32'h00);
			pm_u.drive(12'd80, 1'b1, 1'b0);
			wait_state(3'd2, 20);
			pm_u.drive(12'd49, 1'b1, 1'b0);
			ticks(3);
			cmp_lights(5'b00010);
			cmp_word({31'h0, aux_relay}, a);
			pm_u.drive(12'd50, 1'b1, 1'b0);
			ticks(3);
			cmp_lights(5'b00000);
			cmp_word({31'h0, aux_relay}, 32'h0);
		end
		// overload while running, then the cooling time
		pm_u.drive(12'd200, 1'b1, 1'b0);
		wait_state(3'd4, 5);
		t0 = cyc;
		cmp_lights(5'b10101);
		pm_u.drive(12'd0, 1'b1, 1'b0);
		ticks(20);
		pm_u.hold(1'b1, 1'b0, 3 * TCY);
		wait_state(3'd4, 1);
		wait_state(3'd3, 200);
		cmp_word(32'(cyc - t0 >= 45 * TCY), 32'h1);
		ticks(3);
		rd_chk(msml_pkg::MEM_OFF, 32'h0);
		pm_u.hold(1'b1, 1'b0, 3 * TCY);
		wait_state(3'd0, 5);
		// start defeat and a trip that never locks out
		apb(1'b1, msml_pkg::OPT_OFF, 32'h11);
		pm_u.drive(12'd100, 1'b1, 1'b0);
		ticks(6);
		wait_state(3'd2, 1);
		pm_u.drive(12'd100, 1'b1, 1'b1);
		wait_state(3'd3, 5);
		cmp_lights(5'b10000);
		pm_u.drive(12'd0, 1'b1, 1'b0);
		pm_u.hold(1'b1, 1'b0, 3 * TCY);
		wait_state(3'd0, 5);
		// memory defeat turns the start trip into a plain trip
		apb(1'b1, msml_pkg::OPT_OFF, 32'h12);
		pm_u.drive(12'd200, 1'b1, 1'b0);
		wait_state(3'd3, 40);
		cmp_lights(5'b11100);
		pm_u.drive(12'd0, 1'b1, 1'b0);
		pm_u.hold(1'b1, 1'b0, 3 * TCY);
		wait_state(3'd0, 5);
		// power loss during lockout, short and then past the cooling time
		apb(1'b1, msml_pkg::OPT_OFF, 32'h10);
		pm_u.drive(12'd200, 1'b1, 1'b0);
		wait_state(3'd4, 40);
		pm_u.drive(12'd0, 1'b0, 1'b0);
		wait_state(3'd5, 5);
		ticks(5);
		pm_u.drive(12'd0, 1'b1, 1'b0);
		wait_state(3'd4, 5);
		cmp_lights(5'b10001);
		pm_u.drive(12'd0, 1'b0, 1'b0);
		ticks(60);
		pm_u.drive(12'd0, 1'b1, 1'b0);
		ticks(3);
		cmp_word({31'h0, lights.lockout}, 32'h0);
		// power loss while running must not relock at power return
		pm_u.drive(12'd80, 1'b1, 1'b0);
		wait_state(3'd2, 20);
		pm_u.drive(12'd0, 1'b0, 1'b0);
		wait_state(3'd5, 5);
		pm_u.drive(12'd0, 1'b1, 1'b0);
		wait_state(3'd0, 5);
		test_done();
	end

	// the tests take some 1100 cycles
	initial
	begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		test_done();
	end
endmodule // msml_top_tb_top
